/* include/prio_bank_pkg.sv */
`default_nettype none
package prio_bank_pkg;

	// ==========================================================
	// Register map (byte addresses, one aligned word each)
	localparam logic [11:0] OFS_SEVEN    = 12'h000;
	localparam logic [11:0] OFS_EIGHT    = 12'h004;
	localparam logic [11:0] OFS_NINE     = 12'h008;
	localparam logic [11:0] OFS_TEN      = 12'h00C;
	localparam logic [11:0] OFS_ELEVEN   = 12'h010;
	localparam logic [11:0] OFS_TWELVE   = 12'h014;
	localparam logic [11:0] OFS_THIRTEEN = 12'h018;
	localparam logic [11:0] OFS_STATUS   = 12'h01C;

	localparam int NUM_REGS   = 7;
	localparam int FIELD_W    = 3;
	localparam int FIELDS     = 4;
	localparam int REG_W      = 16;
	localparam int NUM_SRC    = NUM_REGS * FIELDS;

	// ==========================================================
	// Field layout: field k sits at bits 4k+2..4k
	localparam int FIELD_STRIDE = 4;

	// Codes
	localparam logic [2:0] PRIO_OFF     = 3'h0;
	localparam logic [2:0] PRIO_LOWEST  = 3'h1;
	localparam logic [2:0] PRIO_HIGHEST = 3'h7;
	localparam logic [2:0] PRIO_RESET   = 3'h4;

	// Implemented-bit masks and reset value per register (seven .. thirteen)
	localparam logic [15:0] MASK_FULL   = 16'h7777;
	localparam logic [15:0] MASK_ELEVEN = 16'h7707;
	localparam logic [15:0] RESET_FULL  = 16'h4444;

	// Status register: source-enabled summary
	localparam int STATUS_W = NUM_SRC;

	// ==========================================================
	typedef struct packed {
		logic [11:0] addr;
		logic        write;
		logic [31:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic [2:0] level;
		logic       enabled;
	} src_prio_t;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_ACCESS = 2'b01,
		ST_DONE   = 2'b10
	} apb_state_t;

endpackage
`default_nettype wire

/* logic/prio_bank.sv */
`timescale 1ns/100ps
`default_nettype none
// Operation
// RULE1: Field code 111 means priority level 7, the highest.
// RULE2: Field code 001 means priority level 1, the lowest enabled.
// RULE3: Field code 000 disables the source; never shown as enabled.
// RULE4: Unimplemented bits read zero and ignore writes.
// RULE5: At reset each field loads 100.
// RULE6: Register seven: serial2 tx, serial2 rx, ext irq2, timer5.
// RULE7: Register eight: can1 event, can1 rx ready, spi2 event, spi2 error.
// RULE8: Register nine: capture5, capture4, capture3, dma ch3 done.
// RULE9: Register ten: compare7, compare6, compare5, capture6.
// RULE10: Register eleven: timer6, dma ch4 done, bits 7-3 empty, compare8.
// RULE11: Register twelve: timer8, i2c2 master, i2c2 slave, timer7.
// RULE12: Register thirteen: can2 rx ready, ext irq4, ext irq3, timer9.
// RULE13: After reset every source here has priority level 4.
// RULE14: Codes 010 to 110 give levels 2 to 6 directly.
// RULE15: Field values drive arbitration continuously, next cycle after write.
module prio_bank (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [2:0]  serial2_tx_priority,
	output logic      [2:0]  serial2_rx_priority,
	output logic      [2:0]  ext_irq2_priority,
	output logic      [2:0]  timer5_priority,
	output logic      [2:0]  can1_event_priority,
	output logic      [2:0]  can1_rx_ready_priority,
	output logic      [2:0]  spi2_event_priority,
	output logic      [2:0]  spi2_error_priority,
	output logic      [2:0]  capture5_priority,
	output logic      [2:0]  capture4_priority,
	output logic      [2:0]  capture3_priority,
	output logic      [2:0]  dma_ch3_done_priority,
	output logic      [2:0]  compare7_priority,
	output logic      [2:0]  compare6_priority,
	output logic      [2:0]  compare5_priority,
	output logic      [2:0]  capture6_priority,
	output logic      [2:0]  timer6_priority,
	output logic      [2:0]  dma_ch4_done_priority,
	output logic      [2:0]  compare8_priority,
	output logic      [2:0]  timer8_priority,
	output logic      [2:0]  i2c2_master_priority,
	output logic      [2:0]  i2c2_slave_priority,
	output logic      [2:0]  timer7_priority,
	output logic      [2:0]  can2_rx_ready_priority,
	output logic      [2:0]  ext_irq4_priority,
	output logic      [2:0]  ext_irq3_priority,
	output logic      [2:0]  timer9_priority,
	output logic      [27:0] source_enabled
);

	// ==========================================================
	// Bus decode
	localparam int NR = prio_bank_pkg::NUM_REGS;
	localparam int NS = prio_bank_pkg::NUM_SRC;
	localparam int FW = prio_bank_pkg::FIELD_W;
	localparam int NF = prio_bank_pkg::FIELDS;
	localparam int FS = prio_bank_pkg::FIELD_STRIDE;
	// Register eleven carries the one empty field slot
	localparam int ELEVEN = 4;
	localparam int GAP    = ELEVEN * NF + 1;
	localparam logic [NS-1:0] EN_RESET = ~({{(NS - 1){1'b0}}, 1'b1} << GAP);

	prio_bank_pkg::bus_req_t req;
	logic [NR-1:0]           sel;
	logic [NR-1:0]           wr_sel;
	logic                    hit_status;
	logic                    mapped;
	logic                    access;
	logic [15:0]             regs [NR];
	logic [15:0]             wdata16;

	always_comb begin
		req.addr   = paddr;
		req.write  = pwrite;
		req.wdata  = pwdata;
		wdata16    = req.wdata[15:0];
		access     = psel & penable;
		hit_status = (req.addr == prio_bank_pkg::OFS_STATUS);
		sel        = '0;
		case (req.addr)
			prio_bank_pkg::OFS_SEVEN:    sel[0] = 1'b1;
			prio_bank_pkg::OFS_EIGHT:    sel[1] = 1'b1;
			prio_bank_pkg::OFS_NINE:     sel[2] = 1'b1;
			prio_bank_pkg::OFS_TEN:      sel[3] = 1'b1;
			prio_bank_pkg::OFS_ELEVEN:   sel[4] = 1'b1;
			prio_bank_pkg::OFS_TWELVE:   sel[5] = 1'b1;
			prio_bank_pkg::OFS_THIRTEEN: sel[6] = 1'b1;
			default:                     sel    = '0;
		endcase
		mapped = (|sel) | hit_status;
		// Only the first access edge writes; the answer cycle is idle
		wr_sel = sel & {NR{access & req.write & ~pready}};
	end

	// ==========================================================
	// Register instances; eleven has bits 7-3 unimplemented
	genvar g;
	generate
		for (g = 0; g < NR; g++) begin : g_reg
			prio_reg16 #(
				.IMPL_MASK ((g == ELEVEN) ? prio_bank_pkg::MASK_ELEVEN
				                          : prio_bank_pkg::MASK_FULL)
			) u_reg (
				.clk   (clk),
				.rst_b (rst_b),
				.wr_en (wr_sel[g]),
				.wdata (wdata16),
				.value (regs[g])
			);                                                     // RULE4 RULE10
		end
	endgenerate

	// ==========================================================
	// Field decode per source, on the next register contents so
	// the output copy moves on the write edge, not a cycle behind
	logic [15:0]              regs_nxt [NR];
	logic [2:0]               code [NS];
	prio_bank_pkg::src_prio_t dec  [NS];
	logic [NS-1:0]            en_vec;
	logic [2:0]               fld_r [NS];
	logic [NS-1:0]            en_r;

	always_comb begin
		for (int r = 0; r < NR; r++) begin
			regs_nxt[r] = regs[r];
			if (wr_sel[r] && (r == ELEVEN)) begin
				regs_nxt[r] = wdata16 & prio_bank_pkg::MASK_ELEVEN;  // RULE4
			end else if (wr_sel[r]) begin
				regs_nxt[r] = wdata16 & prio_bank_pkg::MASK_FULL;    // RULE4
			end
		end
	end

	generate
		for (g = 0; g < NS; g++) begin : g_src
			assign code[g] = regs_nxt[g / NF][(g % NF) * FS +: FW];
			prio_decode u_dec (
				.code (code[g]),
				.prio (dec[g])
			);
			assign en_vec[g] = dec[g].enabled;                      // RULE3
		end
	endgenerate

	// ==========================================================
	// APB slave: one wait state, answer registered
	prio_bank_pkg::apb_state_t st_r;
	prio_bank_pkg::apb_state_t st_nxt;
	logic [31:0]               prdata_r;
	logic [31:0]               prdata_nxt;
	logic                      pready_nxt;
	logic                      pslverr_nxt;
	logic [31:0]               rd_mux;

	always_comb begin
		rd_mux = 32'h0000_0000;
		for (int i = 0; i < NR; i++) begin
			if (sel[i]) begin
				rd_mux = {16'h0000, regs[i]};                       // RULE4
			end
		end
		if (hit_status) begin
			rd_mux = {4'h0, en_r};                                  // RULE3
		end
	end

	always_comb begin
		st_nxt      = st_r;
		prdata_nxt  = prdata_r;
		pready_nxt  = 1'b0;
		pslverr_nxt = 1'b0;
		case (st_r)
			prio_bank_pkg::ST_IDLE: begin
				if (access) begin
					st_nxt      = prio_bank_pkg::ST_DONE;
					pready_nxt  = 1'b1;
					pslverr_nxt = ~mapped;
					prdata_nxt  = req.write ? 32'h0000_0000 : rd_mux;
				end
			end
			prio_bank_pkg::ST_DONE: begin
				st_nxt = prio_bank_pkg::ST_IDLE;
			end
			default: begin
				st_nxt = prio_bank_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r     <= prio_bank_pkg::ST_IDLE;
			prdata_r <= 32'h0000_0000;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
		end else begin
			st_r     <= st_nxt;
			prdata_r <= prdata_nxt;
			pready   <= pready_nxt;
			pslverr  <= pslverr_nxt;
		end
	end

	assign prdata = prdata_r;

	// ==========================================================
	// Arbitration-facing outputs: a flop copy of every field,
	// loaded from the same next value as the register itself,
	// so pins stay flop-driven without adding latency
	logic [2:0]    fld_nxt [NS];
	logic [NS-1:0] en_nxt;

	always_comb begin
		for (int i = 0; i < NS; i++) begin
			fld_nxt[i] = dec[i].level;                             // RULE15
		end
		en_nxt = en_vec;                                           // RULE3
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NS; i++) begin
				fld_r[i] <= (i == GAP) ? prio_bank_pkg::PRIO_OFF
				                       : prio_bank_pkg::PRIO_RESET; // RULE13
			end
			en_r <= EN_RESET;                                      // RULE3
		end else begin
			for (int i = 0; i < NS; i++) begin
				fld_r[i] <= fld_nxt[i];
			end
			en_r <= en_nxt;
		end
	end

	// Empty slot of register eleven has no pin of its own
	assign source_enabled         = en_r;
	assign serial2_tx_priority    = fld_r[3];                      // RULE6
	assign serial2_rx_priority    = fld_r[2];
	assign ext_irq2_priority      = fld_r[1];
	assign timer5_priority        = fld_r[0];
	assign can1_event_priority    = fld_r[7];                      // RULE7
	assign can1_rx_ready_priority = fld_r[6];
	assign spi2_event_priority    = fld_r[5];
	assign spi2_error_priority    = fld_r[4];
	assign capture5_priority      = fld_r[11];                     // RULE8
	assign capture4_priority      = fld_r[10];
	assign capture3_priority      = fld_r[9];
	assign dma_ch3_done_priority  = fld_r[8];
	assign compare7_priority      = fld_r[15];                     // RULE9
	assign compare6_priority      = fld_r[14];
	assign compare5_priority      = fld_r[13];
	assign capture6_priority      = fld_r[12];
	assign timer6_priority        = fld_r[19];                     // RULE10
	assign dma_ch4_done_priority  = fld_r[18];
	assign compare8_priority      = fld_r[16];
	assign timer8_priority        = fld_r[23];                     // RULE11
	assign i2c2_master_priority   = fld_r[22];
	assign i2c2_slave_priority    = fld_r[21];
	assign timer7_priority        = fld_r[20];
	assign can2_rx_ready_priority = fld_r[27];                     // RULE12
	assign ext_irq4_priority      = fld_r[26];
	assign ext_irq3_priority      = fld_r[25];
	assign timer9_priority        = fld_r[24];

endmodule
`default_nettype wire

/* logic/prio_decode.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Field code to level and enable
module prio_decode (
	input  wire logic [2:0]                   code,
	output var  prio_bank_pkg::src_prio_t     prio
);
	always_comb begin
		prio.level   = code;                                 // RULE14 RULE1 RULE2
		prio.enabled = (code != prio_bank_pkg::PRIO_OFF);    // RULE3
	end
endmodule
`default_nettype wire

/* logic/prio_reg16.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// One priority register with implemented-bit mask
module prio_reg16 #(
	parameter logic [15:0] IMPL_MASK = prio_bank_pkg::MASK_FULL
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        wr_en,
	input  wire logic [15:0] wdata,
	output logic      [15:0] value
);
	logic [15:0] value_r;
	logic [15:0] value_nxt;

	always_comb begin
		value_nxt = value_r;
		if (wr_en) begin
			value_nxt = wdata & IMPL_MASK;                          // RULE4
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			value_r <= prio_bank_pkg::RESET_FULL & IMPL_MASK;      // RULE5 RULE13
		end else begin
			value_r <= value_nxt;
		end
	end

	assign value = value_r;
endmodule
`default_nettype wire

/* sim/interrupt_priority_config_bank_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module interrupt_priority_config_bank_tb;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	wire  logic [31:0] prdata;
	wire  logic        pready, pslverr, any_enabled_r;
	wire  logic [27:0] source_enabled;
	wire  logic [2:0]  serial2_tx_priority, serial2_rx_priority,
		ext_irq2_priority, timer5_priority, can1_event_priority,
		can1_rx_ready_priority, spi2_event_priority, spi2_error_priority,
		capture5_priority, capture4_priority, capture3_priority,
		dma_ch3_done_priority, compare7_priority, compare6_priority,
		compare5_priority, capture6_priority, timer6_priority,
		dma_ch4_done_priority, compare8_priority, timer8_priority,
		i2c2_master_priority, i2c2_slave_priority, timer7_priority,
		can2_rx_ready_priority, ext_irq4_priority, ext_irq3_priority,
		timer9_priority;
	// Field i = 4*register + field, empty slot 17 held at zero
	wire  logic [83:0] pv = {can2_rx_ready_priority, ext_irq4_priority,
		ext_irq3_priority, timer9_priority, timer8_priority,
		i2c2_master_priority, i2c2_slave_priority, timer7_priority,
		timer6_priority, dma_ch4_done_priority, 3'h0, compare8_priority,
		compare7_priority, compare6_priority, compare5_priority,
		capture6_priority, capture5_priority, capture4_priority,
		capture3_priority, dma_ch3_done_priority, can1_event_priority,
		can1_rx_ready_priority, spi2_event_priority, spi2_error_priority,
		serial2_tx_priority, serial2_rx_priority, ext_irq2_priority,
		timer5_priority};
	int          num_errors = 0;
	int          checks = 0;
	int          cycles = 0;

	prio_bank DUT (.*);
	prio_arbiter_model u_arb (.clk(clk), .rst_b(rst_b),
		.source_enabled(source_enabled), .any_enabled_r(any_enabled_r));

	always #5 clk = ~clk;

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Long enough for fourteen full passes of about 206 cycles; a hang ends the run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [31:0] exp, input logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		if (!w) chk(prdata, exp);
		chk({31'h0, pslverr}, {31'h0, e});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [15:0] patw(int r);
		logic [15:0] w;
		w = 16'h8888;
		for (int k = 0; k < 4; k++) w[4*k +: 3] = 3'(4*r + k);
		return w;
	endfunction

	task automatic check_state(input logic rst);
		logic [15:0] m;
		logic [2:0]  f;
		logic [31:0] s;
		s = 32'h0;
		for (int r = 0; r < 7; r++) begin
			m = (r == 4) ? prio_bank_pkg::MASK_ELEVEN : prio_bank_pkg::MASK_FULL;
			apb(1'b0, 12'(4*r), 32'h0,
				{16'h0, m & (rst ? prio_bank_pkg::RESET_FULL : patw(r))}, 1'b0);
		end
		for (int i = 0; i < 28; i++) begin
			f = (i == 17) ? 3'h0 : (rst ? 3'h4 : 3'(i));
			s[i] = (f != 3'h0);
			chk({29'h0, pv[3*i +: 3]}, {29'h0, f});
		end
		chk({4'h0, source_enabled}, s);
		chk({31'h0, any_enabled_r}, {31'h0, |s});
		apb(1'b0, prio_bank_pkg::OFS_STATUS, 32'h0, s, 1'b0);
	endtask

	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		check_state(1'b1);
		$display("test reset values done");
		for (int r = 0; r < 7; r++) begin
			apb(1'b1, 12'(4*r), {16'hFFFF, patw(r)}, 32'h0, 1'b0);
		end
		check_state(1'b0);
		$display("test field placement done");
		apb(1'b1, 12'h020, 32'h0000_0000, 32'h0, 1'b1);
		apb(1'b0, 12'h020, 32'h0, 32'h0, 1'b1);
		apb(1'b1, prio_bank_pkg::OFS_STATUS, 32'h0, 32'h0, 1'b0);
		check_state(1'b0);
		$display("test refused access done");
		for (int r = 0; r < 7; r++) begin
			apb(1'b1, 12'(4*r), 32'h0, 32'h0, 1'b0);
		end
		// Model flag trails the enables by one edge
		@(posedge clk);
		chk({4'h0, source_enabled}, 32'h0);
		chk({31'h0, |pv}, 32'h0);
		chk({31'h0, any_enabled_r}, 32'h0);
		$display("test all disabled done");
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		check_state(1'b1);
		$display("test second reset done");
		end_of_test();
	end
endmodule

bind prio_bank prio_bank_properties u_props (.clk(clk), .rst_b(rst_b),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready),
	.timer5_priority(timer5_priority), .timer9_priority(timer9_priority),
	.compare8_priority(compare8_priority),
	.source_enabled(source_enabled));
`default_nettype wire

/* sim/prio_arbiter_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Far-side reader: flags any source that may request
module prio_arbiter_model (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [27:0] source_enabled,
	output var  logic        any_enabled_r
);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			any_enabled_r <= 1'b0;
		end else begin
			any_enabled_r <= |source_enabled;
		end
	end
endmodule
`default_nettype wire

/* sim/prio_bank_properties.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Bus and field checks
module prio_bank_properties (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic [2:0]  timer5_priority,
	input wire logic [2:0]  timer9_priority,
	input wire logic [2:0]  compare8_priority,
	input wire logic [27:0] source_enabled
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_take(logic [11:0] a);
		psel && penable && !pready && pwrite && paddr == a;
	endsequence
	sequence s_reg_read;
		pready && !pwrite && paddr < 12'h01C;
	endsequence

	a_read_masked: assert property (s_reg_read |->
		prdata[31:16] == 16'h0000 && (prdata[15:0] & 16'h8888) == 16'h0000)
		else $error("reserved bits read nonzero");
	a_eleven_gap: assert property (
		pready && !pwrite && paddr == 12'h010 |-> prdata[7:3] == 5'h00)
		else $error("empty field of register eleven reads nonzero");
	a_gap_unset: assert property (rst_b && $past(rst_b) |->
		!source_enabled[17])
		else $error("empty field shown as enabled");
	a_off_low: assert property (
		source_enabled[0] == (timer5_priority != 3'h0))
		else $error("enable of timer5 disagrees with its code");
	a_off_high: assert property (
		source_enabled[24] == (timer9_priority != 3'h0))
		else $error("enable of timer9 disagrees with its code");
	a_write_shown: assert property (s_take(12'h000) |->
		##1 timer5_priority == $past(pwdata[2:0]))
		else $error("timer5 output missed the write");
	a_eleven_shown: assert property (s_take(12'h010) |->
		##1 compare8_priority == $past(pwdata[2:0]))
		else $error("compare8 output missed the write");
	a_hold_value: assert property (!$past(psel && penable && pwrite)
		|-> $stable(timer9_priority))
		else $error("timer9 output moved without a write");
endmodule
`default_nettype wire
